/* rtl/asrr_pkg.sv */
package asrr_pkg;
   // register byte offsets
   localparam logic [7:0] ASRR_OFS_CTRL = 8'h00;
   localparam logic [7:0] ASRR_OFS_DIV = 8'h04;
   localparam logic [7:0] ASRR_OFS_STAT = 8'h08;
   localparam logic [7:0] ASRR_OFS_MASK = 8'h0c;
   localparam logic [7:0] ASRR_OFS_DHI = 8'h10;
   localparam logic [7:0] ASRR_OFS_DLO = 8'h14;
   // control_reg_one/two bits, gathered in one word
   localparam int ASRR_CTL_W = 4;
   localparam int ASRR_CTL_M9 = 0;
   localparam int ASRR_CTL_RIE = 1;
   localparam int ASRR_CTL_BREAK_DETECT_ENABLE = 2;
   localparam int ASRR_CTL_STBY = 3;
   localparam logic [3:0] ASRR_CTL_RST = 4'h0;
   // status_reg_one bits, mask uses the same layout
   localparam int ASRR_ST_W = 4;
   localparam int ASRR_ST_FULL = 0;
   localparam int ASRR_ST_NOISE = 1;
   localparam int ASRR_ST_FE = 2;
   localparam int ASRR_ST_BRK = 3;
   localparam logic [3:0] ASRR_MASK_RST = 4'h0;
   // sample clock divisor reset value (bus clocks per slot)
   localparam logic [15:0] ASRR_DIV_RST = 16'h0010;
   localparam logic [15:0] ASRR_DIV_MIN = 16'h0001;
   // slots of the sample clock within one bit
   localparam logic [4:0] ASRR_RT_FIRST = 5'h01;
   localparam logic [4:0] ASRR_RT_LAST = 5'h10;
   localparam logic [4:0] ASRR_RT_V1 = 5'h03;
   localparam logic [4:0] ASRR_RT_V2 = 5'h05;
   localparam logic [4:0] ASRR_RT_V3 = 5'h07;
   localparam logic [4:0] ASRR_RT_D1 = 5'h08;
   localparam logic [4:0] ASRR_RT_D2 = 5'h09;
   localparam logic [4:0] ASRR_RT_D3 = 5'h0a;
   // window around a bit boundary in which an edge resyncs
   localparam logic [4:0] ASRR_RT_LATE = 5'h0c;
   localparam logic [4:0] ASRR_RT_EARLY = 5'h04;
   localparam logic [3:0] ASRR_BITS8 = 4'h8;
   localparam logic [3:0] ASRR_BITS9 = 4'h9;
   localparam logic [1:0] ASRR_RESP_OK = 2'b00;
   localparam logic [1:0] ASRR_RESP_ERR = 2'b10;

   typedef enum logic [1:0] {
      ASRR_IDLE,
      ASRR_START,
      ASRR_DATA,
      ASRR_STOP
   } asrr_state_t;

   // majority of three samples
   function automatic logic asrr_vote(input logic [2:0] s);
      asrr_vote = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
   endfunction

   // three samples that do not all agree
   function automatic logic asrr_split(input logic [2:0] s);
      asrr_split = (|s) & ~(&s);
   endfunction
endpackage

/* rtl/asrr_rx.sv */
// Notes on behaviour
// - 8 or 9 data bits by length bit; ninth bit lands in data_high_reg
// - completed frame loads data register and sets rx_full_flag
// - rx_full_flag with rx_irq_enable raises the interrupt
// - sample clock is sixteen times baud; sixteen slots per bit
// - sample clock restarts after start edge and after 1-to-0 data change
// - start search wants three ones then a zero; then slots count
// - start checked at slots 3,5,7; at most one one; one one is noise
// - failed start check restarts search, no noise flag
// - data bit is majority of slots 8,9,10; disagreement is noise
// - start slots 8..10 never reject; any one there is noise
// - stop majority zero is framing error; disagreement is noise
// - noise before a verified start never sets noise flag
// - framing error set in same cycle as rx_full_flag
// - break character sets framing error
// - valid falling edges inside a frame resync the slot counter
// - stop sampling starts 151 slots after edge (167 for 9-bit)
// - break with detect enabled sets break flag, not full or framing error, keeps data
// - in standby data still loads but rx_full_flag stays
//
// Our own choices: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module asrr_rx
   import asrr_pkg::*;
#(
   parameter int DIV_W = 16,
   parameter int AW = 8
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic rx_pin,
   output logic irq,
   input wire logic [AW-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [AW-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);

   // divisor register is at most 16 bits wide; address must hold the offsets
   if (DIV_W < 1 || DIV_W > 16 || AW < 8) begin : g_chk
      $error("asrr_rx: DIV_W must be 1..16 and AW at least 8");
   end

   // registers seen by software
   logic [ASRR_CTL_W-1:0] ctrl_r;
   logic [DIV_W-1:0] div_r;
   logic [ASRR_ST_W-1:0] stat_r;
   logic [ASRR_ST_W-1:0] mask_r;
   logic [8:0] data_r;
   logic irq_r;

   // bus slave state
   logic awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
   logic [1:0] bresp_r, rresp_r;
   logic [31:0] rdata_r;
   logic [AW-1:0] awaddr_r;
   logic [31:0] wdata_r;
   logic [3:0] wstrb_r;

   // receiver state
   asrr_state_t state_r;
   logic rx_meta_r, rx_sync_r;
   logic [DIV_W-1:0] div_cnt_r;
   logic [2:0] hist_r;
   logic [4:0] rt_r;
   logic [3:0] bit_r;
   logic [1:0] samp_r;
   logic [8:0] shreg_r;
   logic noise_r, prev_one_r, all_zero_r;
   // one-cycle frame end events
   logic ev_load_r, ev_full_r, ev_noise_r, ev_fe_r, ev_brk_r;

   // controls
   wire m9 = ctrl_r[ASRR_CTL_M9];
   wire rx_irq_enable = ctrl_r[ASRR_CTL_RIE];
   wire break_detect_enable = ctrl_r[ASRR_CTL_BREAK_DETECT_ENABLE];
   wire stby = ctrl_r[ASRR_CTL_STBY];
   wire [3:0] nbits = m9 ? ASRR_BITS9 : ASRR_BITS8;

   // sample clock: one enable pulse per slot
   wire tick = (div_cnt_r == '0);
   wire [DIV_W-1:0] div_load = div_r - DIV_W'(ASRR_DIV_MIN);

   // sample vector: two captured slots and the present one
   wire [2:0] sv = {samp_r, rx_sync_r};
   wire vote = asrr_vote(sv);
   wire split = asrr_split(sv);
   wire fall = (hist_r == 3'b111) & ~rx_sync_r;
   wire rt_wrap = (rt_r == ASRR_RT_LAST);
   wire [4:0] rt_inc = rt_r + ASRR_RT_FIRST;
   wire [3:0] bit_inc = bit_r + 4'h1;
   wire cap = (rt_r == ASRR_RT_V1) | (rt_r == ASRR_RT_V2)
      | (rt_r == ASRR_RT_D1) | (rt_r == ASRR_RT_D2);
   // in-frame edge after a one, near a bit boundary
   wire resync = prev_one_r & fall
      & ((rt_r >= ASRR_RT_LATE) | (rt_r <= ASRR_RT_EARLY));
   wire [8:0] shifted = {vote, shreg_r[8:1]};
   wire [8:0] char_val = m9 ? shreg_r : {1'b0, shreg_r[8:1]};

   // pin synchroniser; only the second stage is looked at
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rx_meta_r <= 1'b1;
         rx_sync_r <= 1'b1;
      end else begin
         rx_meta_r <= rx_pin;
         rx_sync_r <= rx_meta_r;
      end
   end

   // slot divider; a detected edge is always on a tick, so the
   // divider phase already lines up with it
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         div_cnt_r <= '0;
         hist_r <= 3'b000;
      end else if (tick) begin
         div_cnt_r <= div_load;
         hist_r <= {hist_r[1:0], rx_sync_r};
      end else begin
         div_cnt_r <= div_cnt_r - DIV_W'(ASRR_DIV_MIN);
      end
   end

   // frame recovery state machine
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= ASRR_IDLE;
         rt_r <= ASRR_RT_FIRST;
         bit_r <= 4'h0;
         samp_r <= 2'b00;
         shreg_r <= 9'h000;
         noise_r <= 1'b0;
         prev_one_r <= 1'b0;
         all_zero_r <= 1'b1;
         ev_load_r <= 1'b0;
         ev_full_r <= 1'b0;
         ev_noise_r <= 1'b0;
         ev_fe_r <= 1'b0;
         ev_brk_r <= 1'b0;
      end else begin
         ev_load_r <= 1'b0;
         ev_full_r <= 1'b0;
         ev_noise_r <= 1'b0;
         ev_fe_r <= 1'b0;
         ev_brk_r <= 1'b0;
         if (tick) begin
            if (cap) begin
               samp_r <= {samp_r[0], rx_sync_r};
            end
            if (state_r != ASRR_IDLE) begin
               rt_r <= rt_wrap ? ASRR_RT_FIRST : rt_inc;
            end
            case (state_r)
               ASRR_IDLE: begin
                  if (fall) begin
                     state_r <= ASRR_START;
                     rt_r <= ASRR_RT_FIRST + ASRR_RT_FIRST;
                     noise_r <= 1'b0;
                     all_zero_r <= 1'b1;
                     prev_one_r <= 1'b0;
                     shreg_r <= 9'h000;
                  end
               end
               ASRR_START: begin
                  if (rt_r == ASRR_RT_V3) begin
                     if (vote) begin
                        // rejected: no noise recorded
                        state_r <= ASRR_IDLE;
                        rt_r <= ASRR_RT_FIRST;
                     end else if (split) begin
                        noise_r <= 1'b1;
                     end
                  end
                  if (rt_r == ASRR_RT_D3 && (|sv)) begin
                     noise_r <= 1'b1;
                  end
                  if (rt_wrap) begin
                     state_r <= ASRR_DATA;
                     bit_r <= 4'h1;
                  end
               end
               ASRR_DATA: begin
                  if (rt_r == ASRR_RT_D3) begin
                     shreg_r <= shifted;
                     prev_one_r <= vote;
                     all_zero_r <= all_zero_r & ~vote;
                     if (split) begin
                        noise_r <= 1'b1;
                     end
                  end
                  if (resync) begin
                     // restart slots on the new bit's edge
                     rt_r <= ASRR_RT_FIRST + ASRR_RT_FIRST;
                     prev_one_r <= 1'b0;
                  end
                  if (rt_wrap || (resync && rt_r >= ASRR_RT_LATE)) begin
                     bit_r <= bit_inc;
                     if (bit_r == nbits) begin
                        state_r <= ASRR_STOP;
                     end
                  end
               end
               ASRR_STOP: begin
                  if (rt_r == ASRR_RT_D3) begin
                     state_r <= ASRR_IDLE;
                     rt_r <= ASRR_RT_FIRST;
                     ev_noise_r <= noise_r | split;
                     if (break_detect_enable && all_zero_r && !vote) begin
                        ev_brk_r <= 1'b1;
                     end else begin
                        ev_load_r <= 1'b1;
                        ev_full_r <= ~stby;
                        ev_fe_r <= ~vote;
                     end
                  end
               end
               default: begin
                  state_r <= ASRR_IDLE;
               end
            endcase
         end
      end
   end

   // write channel handshake and register decode
   wire aw_hs = s_axi_awvalid & awready_r;
   wire w_hs = s_axi_wvalid & wready_r;
   wire do_wr = ~awready_r & ~wready_r & ~bvalid_r;
   wire wr_ctrl = do_wr & (awaddr_r == AW'(ASRR_OFS_CTRL));
   wire wr_div = do_wr & (awaddr_r == AW'(ASRR_OFS_DIV));
   wire wr_stat = do_wr & (awaddr_r == AW'(ASRR_OFS_STAT));
   wire wr_mask = do_wr & (awaddr_r == AW'(ASRR_OFS_MASK));
   wire wr_ro = do_wr & ((awaddr_r == AW'(ASRR_OFS_DHI))
      | (awaddr_r == AW'(ASRR_OFS_DLO)));
   wire wr_ok = wr_ctrl | wr_div | wr_stat | wr_mask | wr_ro;
   wire [1:0] wr_resp = wr_ok ? ASRR_RESP_OK : ASRR_RESP_ERR;

   // read decode, unmapped reads answer with an error and zero
   wire ar_hs = s_axi_arvalid & arready_r;
   wire [AW-1:0] ra = s_axi_araddr;
   wire rd_ctrl = (ra == AW'(ASRR_OFS_CTRL));
   wire rd_div = (ra == AW'(ASRR_OFS_DIV));
   wire rd_stat = (ra == AW'(ASRR_OFS_STAT));
   wire rd_mask = (ra == AW'(ASRR_OFS_MASK));
   wire rd_dhi = (ra == AW'(ASRR_OFS_DHI));
   wire rd_dlo = (ra == AW'(ASRR_OFS_DLO));
   wire rd_ok = rd_ctrl | rd_div | rd_stat | rd_mask | rd_dhi | rd_dlo;
   wire [31:0] rd_val =
      rd_ctrl ? 32'(ctrl_r) :
      rd_div ? 32'(div_r) :
      rd_stat ? 32'(stat_r) :
      rd_mask ? 32'(mask_r) :
      rd_dhi ? 32'(data_r[8]) :
      rd_dlo ? 32'(data_r[7:0]) : 32'h0000_0000;

   // byte-enable aware field updates
   wire [7:0] wb0 = wdata_r[7:0];
   wire [7:0] wb1 = wdata_r[15:8];
   wire [15:0] div_wide = 16'(div_r);
   wire [15:0] div_new = {wstrb_r[1] ? wb1 : div_wide[15:8],
      wstrb_r[0] ? wb0 : div_wide[7:0]};
   wire div_bad = (div_new[DIV_W-1:0] == '0);
   wire [ASRR_ST_W-1:0] st_clr =
      (wr_stat & wstrb_r[0]) ? wb0[ASRR_ST_W-1:0] : '0;
   wire [ASRR_ST_W-1:0] st_set;
   assign st_set[ASRR_ST_FULL] = ev_full_r;
   assign st_set[ASRR_ST_NOISE] = ev_noise_r;
   assign st_set[ASRR_ST_FE] = ev_fe_r;
   assign st_set[ASRR_ST_BRK] = ev_brk_r;

   // write address and data are taken in either order
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         awready_r <= 1'b1;
         wready_r <= 1'b1;
         awaddr_r <= '0;
         wdata_r <= 32'h0000_0000;
         wstrb_r <= 4'h0;
      end else begin
         if (aw_hs) begin
            awready_r <= 1'b0;
            awaddr_r <= s_axi_awaddr;
         end else if (do_wr) begin
            awready_r <= 1'b1;
         end
         if (w_hs) begin
            wready_r <= 1'b0;
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
         end else if (do_wr) begin
            wready_r <= 1'b1;
         end
      end
   end

   // write response
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         bvalid_r <= 1'b0;
         bresp_r <= ASRR_RESP_OK;
      end else if (do_wr) begin
         bvalid_r <= 1'b1;
         bresp_r <= wr_resp;
      end else if (s_axi_bready) begin
         bvalid_r <= 1'b0;
      end
   end

   // read channel: one read in flight, answer one cycle later
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         arready_r <= 1'b1;
         rvalid_r <= 1'b0;
         rdata_r <= 32'h0000_0000;
         rresp_r <= ASRR_RESP_OK;
      end else if (ar_hs) begin
         arready_r <= 1'b0;
         rvalid_r <= 1'b1;
         rdata_r <= rd_val;
         rresp_r <= rd_ok ? ASRR_RESP_OK : ASRR_RESP_ERR;
      end else if (rvalid_r && s_axi_rready) begin
         rvalid_r <= 1'b0;
         arready_r <= 1'b1;
      end
   end

   // control, divisor and mask; a zero divisor write is ignored
   // since the reload of div_r - 1 would wrap to all ones, the longest slot
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_r <= ASRR_CTL_RST;
         div_r <= DIV_W'(ASRR_DIV_RST);
         mask_r <= ASRR_MASK_RST;
      end else begin
         if (wr_ctrl && wstrb_r[0]) begin
            ctrl_r <= wb0[ASRR_CTL_W-1:0];
         end
         if (wr_div && !div_bad) begin
            div_r <= div_new[DIV_W-1:0];
         end
         if (wr_mask && wstrb_r[0]) begin
            mask_r <= wb0[ASRR_ST_W-1:0];
         end
      end
   end

   // sticky status: a frame event wins over a clear in the same cycle
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         stat_r <= '0;
      end else begin
         stat_r <= (stat_r & ~st_clr) | st_set;
      end
   end

   // data register loads even in standby; a break kept out
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         data_r <= 9'h000;
      end else if (ev_load_r) begin
         data_r <= char_val;
      end
   end

   // interrupt: masked status, plus full with enable outside standby
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_r <= 1'b0;
      end else begin
         irq_r <= (|(stat_r & mask_r))
            | (stat_r[ASRR_ST_FULL] & rx_irq_enable & ~stby);
      end
   end

   assign irq = irq_r;
   assign s_axi_awready = awready_r;
   assign s_axi_wready = wready_r;
   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;
   assign s_axi_arready = arready_r;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rdata = rdata_r;
   assign s_axi_rresp = rresp_r;

endmodule
`default_nettype wire

/* test/asrr_rx_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module asrr_rx_properties
   import asrr_pkg::*;
#(
   parameter int DIV_W = 16,
   parameter int AW = 8
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic irq,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [AW-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   // only six words are decoded, everything else must answer an error
   wire logic rd_unmapped;
   assign rd_unmapped = !(8'(s_axi_araddr) inside {ASRR_OFS_CTRL,
      ASRR_OFS_DIV, ASRR_OFS_STAT, ASRR_OFS_MASK, ASRR_OFS_DHI,
      ASRR_OFS_DLO});

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   // request steps of the register bus
   sequence s_wr_both;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence s_rd_take;
      s_axi_arvalid && s_axi_arready;
   endsequence

   a_write_latency: assert property (
      s_wr_both |=> !s_axi_bvalid && !s_axi_awready
         ##1 s_axi_bvalid && s_axi_awready)
      else $error("write answer not two cycles after request");
   a_aw_refused: assert property (
      s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
      else $error("write address taken again before execution");
   a_read_latency: assert property (
      s_rd_take |=> s_axi_rvalid && !s_axi_arready)
      else $error("read answer not one cycle after request");
   a_ar_blocked: assert property (
      s_axi_rvalid |-> !s_axi_arready)
      else $error("read address open while data pending");
   a_bresp_stands: assert property (
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped before taken");
   a_rdata_stands: assert property (
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
         && $stable(s_axi_rdata) && $stable(s_axi_rresp))
      else $error("read data changed before taken");
   a_unmapped_read: assert property (
      s_rd_take and rd_unmapped |=> s_axi_rresp == ASRR_RESP_ERR
         && s_axi_rdata == 32'h0)
      else $error("unmapped read not answered with error");
   a_reset_idle: assert property (
      $rose(rst_n) |-> s_axi_awready && s_axi_arready && !s_axi_bvalid
         && !s_axi_rvalid && !irq)
      else $error("outputs not idle after reset");
endmodule
`default_nettype wire

/* test/asrr_rx_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module asrr_rx_tb
   import asrr_pkg::*;
;
   localparam logic [3:0] MASK = 4'he;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] awaddr = 8'h00;
   logic [7:0] araddr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0;
   wire logic irq, awready, wready, bvalid, arready, rvalid, rx_pin;
   wire logic [1:0] bresp, rresp;
   wire logic [31:0] rdata;
   int error_cnt = 0;
   int check_count = 0;
   int i;
   logic [31:0] rnd = 32'h6972;
   logic [3:0] m_stat = 4'h0;
   logic [8:0] m_data = 9'h0;

   always #2 clk = ~clk;

   asrr_rx #(.DIV_W(16), .AW(8)) DUT (.clk(clk), .rst_n(rst_n),
      .rx_pin(rx_pin), .irq(irq), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready));
   asrr_serial_src src (.clk(clk), .line(rx_pin));

   function automatic logic [31:0] xs(input logic [31:0] x);
      logic [31:0] y;
      y = x ^ (x << 13);
      y = y ^ (y >> 17);
      xs = y ^ (y << 5);
   endfunction

   task automatic chk(input string nm, input logic [31:0] e,
         input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         $display("unexpected %s expected %h seen %h", nm, e, g);
         error_cnt++;
      end
   endtask

   // address and data offered together, each dropped once taken;
   // bready comes late so the slave must hold its response
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
         input logic [1:0] er);
      logic [1:0] r;
      r = 2'bxx;
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      for (int n = 0; n < 100; n++) begin
         @(posedge clk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid && bready) begin
            r = bresp;
            break;
         end
         if (n >= 2) bready <= 1'b1;
      end
      bready <= 1'b0;
      chk("bresp", {30'h0, er}, {30'h0, r});
   endtask

   // rready comes late on purpose so the slave must hold its answer
   task automatic rd(input logic [7:0] a, output logic [31:0] d,
         output logic [1:0] r);
      d = 'x;
      r = 2'bxx;
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      for (int n = 0; n < 100; n++) begin
         @(posedge clk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid && rready) begin
            d = rdata;
            r = rresp;
            break;
         end
         if (n >= 1) rready <= 1'b1;
      end
      rready <= 1'b0;
   endtask

   task automatic rchk(input string nm, input logic [7:0] a,
         input logic [31:0] e);
      logic [31:0] d;
      logic [1:0] r;
      rd(a, d, r);
      chk(nm, e, d);
      chk("rresp", 32'h0, {30'h0, r});
   endtask

   // one frame through the partner, then the model and the registers
   task automatic frame(input logic [8:0] d, input int bt,
         input logic stop, input int fb, input int fo, input int fl,
         input logic nz, input logic [3:0] c);
      logic ei;
      wr(ASRR_OFS_CTRL, {28'h0, c}, ASRR_RESP_OK);
      if (!c[ASRR_CTL_M9]) d[8] = 1'b0;
      src.send(d, c[ASRR_CTL_M9] ? 9 : 8, bt, stop, fb, fo, fl);
      if (nz) m_stat[ASRR_ST_NOISE] = 1'b1;
      if (d == 9'h0 && !stop && c[ASRR_CTL_BREAK_DETECT_ENABLE]) begin
         m_stat[ASRR_ST_BRK] = 1'b1;
      end else begin
         m_data = d;
         if (!c[ASRR_CTL_STBY]) m_stat[ASRR_ST_FULL] = 1'b1;
         if (!stop) m_stat[ASRR_ST_FE] = 1'b1;
      end
      ei = |(m_stat & MASK) | (m_stat[ASRR_ST_FULL] & c[ASRR_CTL_RIE]);
      for (int n = 0; n < 64 && irq !== ei; n++) @(posedge clk);
      chk("irq", {31'h0, ei}, {31'h0, irq});
      rchk("stat", ASRR_OFS_STAT, {28'h0, m_stat});
      rchk("dlo", ASRR_OFS_DLO, {24'h0, m_data[7:0]});
      rchk("dhi", ASRR_OFS_DHI, {31'h0, m_data[8]});
      wr(ASRR_OFS_STAT, 32'hf, ASRR_RESP_OK);
      m_stat = 4'h0;
      rchk("stat clr", ASRR_OFS_STAT, 32'h0);
      chk("irq clr", 32'h0, {31'h0, irq});
   endtask

   task automatic report_and_stop;
      $display("checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   // a hung handshake would otherwise stall the run forever
   initial begin
      repeat (40000) @(posedge clk);
      error_cnt++;
      report_and_stop();
   end

   initial begin
      logic [31:0] d;
      logic [1:0] r;
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      // reset values, read-only data word, unmapped places
      wr(ASRR_OFS_DLO, 32'hab, ASRR_RESP_OK);
      wr(8'h20, 32'h1, ASRR_RESP_ERR);
      rchk("ctrl", ASRR_OFS_CTRL, 32'h0);
      rchk("div", ASRR_OFS_DIV, {16'h0, ASRR_DIV_RST});
      rchk("stat", ASRR_OFS_STAT, 32'h0);
      rchk("mask", ASRR_OFS_MASK, 32'h0);
      rchk("dhi", ASRR_OFS_DHI, 32'h0);
      rchk("dlo", ASRR_OFS_DLO, 32'h0);
      // a zero divisor would wrap the slot reload to all ones, so it is refused
      wr(ASRR_OFS_DIV, 32'h0, ASRR_RESP_OK);
      rchk("div keep", ASRR_OFS_DIV, {16'h0, ASRR_DIV_RST});
      rd(8'h18, d, r);
      chk("unmapped rresp", {30'h0, ASRR_RESP_ERR}, {30'h0, r});
      // one clock per slot keeps frames short: bit time is 16 clocks
      wr(ASRR_OFS_DIV, 32'h1, ASRR_RESP_OK);
      wr(ASRR_OFS_MASK, {28'h0, MASK}, ASRR_RESP_OK);
      src.glitch(2);
      rchk("stat glitch", ASRR_OFS_STAT, 32'h0);
      for (i = 0; i < 5; i++) begin
         rnd = xs(rnd);
         frame(rnd[8:0], 16, 1'b1, -1, 0, 0, 1'b0, i < 3 ? 4'h2 : 4'h3);
      end
      frame(9'h0f0, 16, 1'b1, -1, 0, 0, 1'b0, 4'h0);
      frame(9'h0a5, 16, 1'b1, 4, 8, 1, 1'b1, 4'h0);
      frame(9'h03c, 16, 1'b1, 0, 2, 1, 1'b1, 4'h0);
      frame(9'h0c3, 16, 1'b1, 0, 7, 3, 1'b1, 4'h2);
      frame(9'h05a, 16, 1'b1, 9, 8, 1, 1'b1, 4'h2);
      frame(9'h081, 16, 1'b0, -1, 0, 0, 1'b0, 4'h0);
      frame(9'h1e1, 16, 1'b0, -1, 0, 0, 1'b0, 4'h3);
      frame(9'h000, 16, 1'b0, -1, 0, 0, 1'b0, 4'h2);
      frame(9'h000, 16, 1'b0, -1, 0, 0, 1'b0, 4'h6);
      frame(9'h055, 17, 1'b1, -1, 0, 0, 1'b0, 4'h2);
      frame(9'h055, 15, 1'b1, -1, 0, 0, 1'b0, 4'h2);
      frame(9'h155, 17, 1'b1, -1, 0, 0, 1'b0, 4'h3);
      frame(9'h07e, 16, 1'b1, -1, 0, 0, 1'b0, 4'ha);
      report_and_stop();
   end
endmodule

bind asrr_rx asrr_rx_properties #(.DIV_W(DIV_W), .AW(AW)) u_props (
   .clk(clk), .rst_n(rst_n), .irq(irq),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
`default_nettype wire

/* test/asrr_serial_src.sv */
`timescale 1ns/1ps
`default_nettype none
module asrr_serial_src (
   input wire logic clk,
   output logic line
);
   // idle high, as a real transmitter leaves the line
   initial line = 1'b1;

   // bit 0 is start, nb+1 is stop; fl clocks inverted from fo of bit fb
   task automatic send(input logic [8:0] d, input int nb, input int bt,
         input logic stop, input int fb, input int fo, input int fl);
      logic v;
      int b;
      int c;
      for (b = 0; b <= nb + 1; b++) begin
         for (c = 0; c < bt; c++) begin
            @(posedge clk);
            v = (b == 0) ? 1'b0 : (b == nb + 1) ? stop : d[b-1];
            line <= v ^ (b == fb && c >= fo && c < fo + fl);
         end
      end
      // idle ones so the next start has three high samples before it
      repeat (8) begin
         @(posedge clk);
         line <= 1'b1;
      end
   endtask

   // short low pulse that a receiver must not take for a start
   task automatic glitch(input int n);
      repeat (n) begin
         @(posedge clk);
         line <= 1'b0;
      end
      repeat (40) begin
         @(posedge clk);
         line <= 1'b1;
      end
   endtask
endmodule
`default_nettype wire
